/* hw/mmd_pkg.sv */
// Package for the memory map decoder: regions, register offsets, field layouts
package mmd_pkg;
   localparam int MMD_AW = 16;
   localparam int MMD_DW = 8;
   // Program space
   localparam logic [15:0] MMD_BOOT_BASE = 16'hfc00;
   // External data space
   localparam logic [15:0] MMD_RAM_LO = 16'h0000;
   localparam logic [15:0] MMD_RAM_HI = 16'h17ff;
   localparam logic [15:0] MMD_MACR_LO = 16'h2000;
   localparam logic [15:0] MMD_MACR_HI = 16'h21ff;
   localparam logic [15:0] MMD_PHY_LO = 16'h2200;
   localparam logic [15:0] MMD_PHY_HI = 16'h22ff;
   localparam logic [15:0] MMD_MACM_LO = 16'h2300;
   localparam logic [15:0] MMD_MACM_HI = 16'h24ff;
   localparam logic [15:0] MMD_PERI_LO = 16'h2500;
   localparam logic [15:0] MMD_PERI_HI = 16'h29ff;
   // Internal data space
   localparam logic [7:0] MMD_BANK_HI = 8'h1f;
   localparam logic [7:0] MMD_BIT_LO = 8'h20;
   localparam logic [7:0] MMD_BIT_HI = 8'h2f;
   localparam logic [7:0] MMD_GP_LO = 8'h30;
   localparam logic [7:0] MMD_GP_HI = 8'h7f;
   localparam logic [7:0] MMD_SFR_LO = 8'h80;
   // Special function registers
   localparam logic [7:0] MMD_PMC_ADDR = 8'hc0;
   localparam logic [7:0] MMD_PSW_ADDR = 8'hd0;
   localparam logic [7:0] MMD_ACC_ADDR = 8'he0;
   localparam int MMD_PMC_LOADER_BIT = 4;
   localparam int MMD_PMC_OVERLAY_BIT = 1;
   localparam logic MMD_PMC_OVERLAY_RST = 1'b1;
   localparam logic [7:0] MMD_ACC_RST = 8'h00;
   localparam logic [7:0] MMD_PSW_RST = 8'h00;
   localparam int MMD_PSW_BANK_LSB = 3;
   localparam logic [2:0] MMD_LOADER_SEL = 3'b100;
   localparam logic [2:0] MMD_BIT_LOW_MASK = 3'b111;

   typedef enum logic [5:0] {
      MMD_X_NONE = 6'h01,
      MMD_X_RAM  = 6'h02,
      MMD_X_MACR = 6'h04,
      MMD_X_PHY  = 6'h08,
      MMD_X_MACM = 6'h10,
      MMD_X_PERI = 6'h20
   } mmd_xsel_e;

   // One access from the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mmd_req_s;
endpackage : mmd_pkg

/* hw/mmd_xdec.sv */
// External data space region decoder
`timescale 1ns/1ps
`default_nettype none
module mmd_xdec (
   input wire logic [15:0] i_addr,
   output var mmd_pkg::mmd_xsel_e o_sel
);
   import mmd_pkg::*;

   function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction : in_rng

   always_comb begin
      if (in_rng(i_addr, MMD_RAM_LO, MMD_RAM_HI)) o_sel = MMD_X_RAM;
      else if (in_rng(i_addr, MMD_MACR_LO, MMD_MACR_HI)) o_sel = MMD_X_MACR;
      else if (in_rng(i_addr, MMD_PHY_LO, MMD_PHY_HI)) o_sel = MMD_X_PHY;
      else if (in_rng(i_addr, MMD_MACM_LO, MMD_MACM_HI)) o_sel = MMD_X_MACM;
      else if (in_rng(i_addr, MMD_PERI_LO, MMD_PERI_HI)) o_sel = MMD_X_PERI;
      else o_sel = MMD_X_NONE;
   end
endmodule : mmd_xdec
`default_nettype wire

/* hw/mmd_top.sv */
// Memory map decoder: program, external data, internal data and SFR spaces
`timescale 1ns/1ps
`default_nettype none
module mmd_top (
   input wire logic i_clk,
   input wire logic i_rst,
   // Program fetch
   input wire logic [15:0] i_fetch_addr,
   output logic o_fetch_rom,
   output logic o_fetch_nvm,
   output logic [15:0] o_fetch_addr,
   // External data move
   input wire mmd_pkg::mmd_req_s i_xreq,
   output logic [5:0] o_xsel,
   output logic o_xrd,
   output logic o_xwr,
   output logic [15:0] o_xaddr,
   output logic [7:0] o_xwdata,
   input wire logic [7:0] i_xrdata,
   output logic [7:0] o_xrdata,
   // Internal data and SFR space
   input wire mmd_pkg::mmd_req_s i_ireq,
   input wire logic i_ibit,
   input wire logic i_sfr,
   output logic [7:0] o_irdata,
   output logic o_ibit_rdata,
   output logic o_ibit_ok,
   output logic [1:0] o_bank,
   // Mode select pins
   input wire logic [2:0] i_mode_select_pins,
   output logic o_loader_mode_flag,
   output logic o_boot_rom_overlay_enable
);
   import mmd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Mode pins: three-stage synchroniser, accept when stages two and three agree
   logic [2:0] pin_s1, pin_s2, pin_s3, pin_ok;
   logic [2:0] next_pin_ok;
   always_comb begin
      next_pin_ok = pin_ok;
      if (pin_s2 == pin_s3) next_pin_ok = pin_s3;
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
         pin_s3 <= 3'h0;
         pin_ok <= 3'h0;
      end else begin
         pin_s1 <= i_mode_select_pins;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_ok <= next_pin_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Special function registers kept here
   logic loader_mode_flag, boot_rom_overlay_enable;
   logic [7:0] main_working_register, program_status_word;
   logic next_loader, next_overlay;
   logic [7:0] next_acc, next_psw;
   logic [7:0] sfr_addr, pmc_read, sfr_rd;
   logic sfr_hit, sfr_bit_ok;

   function automatic logic sfr_impl(input logic [7:0] a);
      sfr_impl = (a == MMD_PMC_ADDR) || (a == MMD_PSW_ADDR) || (a == MMD_ACC_ADDR);
   endfunction : sfr_impl

   // Bit address 0x80+ picks SFR base = addr with low three bits cleared
   assign sfr_addr = i_ibit ? (i_ireq.addr[7:0] & ~{5'h00, MMD_BIT_LOW_MASK})
                            : i_ireq.addr[7:0];
   assign sfr_hit = i_sfr && sfr_impl(sfr_addr);

   always_comb begin
      pmc_read = 8'h00;
      pmc_read[MMD_PMC_LOADER_BIT] = loader_mode_flag;
      pmc_read[MMD_PMC_OVERLAY_BIT] = boot_rom_overlay_enable;
      unique case (sfr_addr)
         MMD_PMC_ADDR: sfr_rd = pmc_read;
         MMD_PSW_ADDR: sfr_rd = program_status_word;
         MMD_ACC_ADDR: sfr_rd = main_working_register;
         default: sfr_rd = 8'h00;
      endcase
   end

   // Bit writes go only to SFRs on eight-byte boundaries; all three qualify
   assign sfr_bit_ok = (sfr_addr[2:0] == 3'h0);

   function automatic logic [7:0] put_bit(input logic [7:0] old, input logic [2:0] idx,
                                           input logic val);
      logic [7:0] r;
      r = old;
      r[idx] = val;
      put_bit = r;
   endfunction : put_bit

   always_comb begin
      logic [7:0] wv;
      wv = 8'h00;
      next_loader = (pin_ok == MMD_LOADER_SEL);
      next_overlay = boot_rom_overlay_enable;
      next_acc = main_working_register;
      next_psw = program_status_word;
      if (i_ireq.wr && sfr_hit && (!i_ibit || sfr_bit_ok)) begin
         wv = i_ibit ? put_bit(sfr_rd, i_ireq.addr[2:0], i_ireq.wdata[0])
                     : i_ireq.wdata;
         unique case (sfr_addr)
            MMD_PMC_ADDR: next_overlay = wv[MMD_PMC_OVERLAY_BIT];
            MMD_PSW_ADDR: next_psw = wv;
            MMD_ACC_ADDR: next_acc = wv;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         loader_mode_flag <= 1'b0;
         boot_rom_overlay_enable <= MMD_PMC_OVERLAY_RST;
         main_working_register <= MMD_ACC_RST;
         program_status_word <= MMD_PSW_RST;
      end else begin
         loader_mode_flag <= next_loader;
         boot_rom_overlay_enable <= next_overlay;
         main_working_register <= next_acc;
         program_status_word <= next_psw;
      end
   end

   assign o_loader_mode_flag = loader_mode_flag;
   assign o_boot_rom_overlay_enable = boot_rom_overlay_enable;
   assign o_bank = program_status_word[MMD_PSW_BANK_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // Internal RAM 0x00-0x7F: banks, bit area, general bytes
   logic [7:0] iram [0:127];
   logic [7:0] iaddr, ird_q, next_ird;
   logic ibit_q, next_ibit, ibok_q, next_ibok;
   logic iram_we;
   logic [7:0] iram_wv;

   // Bit addresses 0x00-0x7F land in bytes 0x20-0x2F
   assign iaddr = (i_ibit && !i_sfr) ? (MMD_BIT_LO + {4'h0, i_ireq.addr[6:3]})
                                     : i_ireq.addr[7:0];

   always_comb begin
      iram_we = i_ireq.wr && !i_sfr && (iaddr <= MMD_GP_HI);
      iram_wv = i_ibit ? put_bit(iram[iaddr[6:0]], i_ireq.addr[2:0], i_ireq.wdata[0])
                       : i_ireq.wdata;
      next_ird = i_sfr ? sfr_rd : ((iaddr <= MMD_GP_HI) ? iram[iaddr[6:0]] : 8'h00);
      next_ibit = next_ird[i_ireq.addr[2:0]];
      next_ibok = i_ibit && (i_sfr ? sfr_bit_ok : 1'b1);
      if (!i_ireq.rd) begin
         next_ird = ird_q;
         next_ibit = ibit_q;
         next_ibok = ibok_q;
      end
   end

   // Indirect register access through the selected bank is resolved by the core
   // as address {bank, r}; storage here is flat so every bank is reachable
   always_ff @(posedge i_clk) begin
      if (iram_we) iram[iaddr[6:0]] <= iram_wv;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ird_q <= 8'h00;
         ibit_q <= 1'b0;
         ibok_q <= 1'b0;
      end else begin
         ird_q <= next_ird;
         ibit_q <= next_ibit;
         ibok_q <= next_ibok;
      end
   end

   assign o_irdata = ird_q;
   assign o_ibit_rdata = ibit_q;
   assign o_ibit_ok = ibok_q;

   ////////////////////////////////////////////////////////////////////////////
   // Program fetch routing
   logic top_kb, rom_sel;
   assign top_kb = (i_fetch_addr >= MMD_BOOT_BASE);
   // Overlay only honoured in loader mode, else ROM is hidden
   assign rom_sel = top_kb && loader_mode_flag && boot_rom_overlay_enable;
   assign o_fetch_rom = rom_sel;
   assign o_fetch_nvm = !rom_sel;
   assign o_fetch_addr = i_fetch_addr;

   ////////////////////////////////////////////////////////////////////////////
   // External data space, external move only
   mmd_xsel_e xsel;
   logic [7:0] xrd_q, next_xrd;
   logic xrd_pend;

   mmd_xdec u_xdec (
      .i_addr(i_xreq.addr),
      .o_sel(xsel)
   );

   // Unmapped accesses reach no target
   assign o_xsel = (xsel == MMD_X_NONE) ? 6'h00 : xsel;
   assign o_xrd = i_xreq.rd && (xsel != MMD_X_NONE);
   assign o_xwr = i_xreq.wr && (xsel != MMD_X_NONE);
   assign o_xaddr = i_xreq.addr;
   assign o_xwdata = i_xreq.wdata;

   logic next_pend;
   always_comb begin
      next_pend = o_xrd;
      next_xrd = xrd_q;
      if (xrd_pend) next_xrd = i_xrdata;
      if (i_xreq.rd && xsel == MMD_X_NONE) next_xrd = 8'h00;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         xrd_q <= 8'h00;
         xrd_pend <= 1'b0;
      end else begin
         xrd_q <= next_xrd;
         xrd_pend <= next_pend;
      end
   end
   assign o_xrdata = xrd_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Flag trails the filtered pins by one edge; gate is checked from the pins
   a_rom_gate: assert property (@(posedge i_clk) disable iff (i_rst)
      o_fetch_rom |-> (i_fetch_addr >= MMD_BOOT_BASE)
      && ($past(pin_ok) == MMD_LOADER_SEL) && boot_rom_overlay_enable)
      else $error("rom selected outside loader overlay");
   a_rom_on: assert property (@(posedge i_clk) disable iff (i_rst)
      ((i_fetch_addr >= MMD_BOOT_BASE) && loader_mode_flag && boot_rom_overlay_enable)
      |-> o_fetch_rom)
      else $error("loader overlay not routed to rom");
   a_low_nvm: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_fetch_addr < MMD_BOOT_BASE) |-> o_fetch_nvm && !o_fetch_rom)
      else $error("low program space not on nvm");
   a_fetch_excl: assert property (@(posedge i_clk) disable iff (i_rst)
      o_fetch_rom != o_fetch_nvm)
      else $error("fetch routed to both or neither memory");
   a_ram_region: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_xreq.rd && i_xreq.addr <= MMD_RAM_HI) |-> o_xsel == MMD_X_RAM)
      else $error("ram region misdecoded");
   a_phy_region: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_xreq.wr && i_xreq.addr[15:8] == MMD_PHY_LO[15:8])
      |-> o_xwr && o_xsel == MMD_X_PHY)
      else $error("phy region misdecoded");
   a_unmap_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_xreq.rd && xsel == MMD_X_NONE) |=> o_xrdata == 8'h00)
      else $error("unmapped read not zero");
   a_sfr_nowrite: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ireq.wr && i_sfr && !sfr_impl(sfr_addr)) |=>
      $stable(main_working_register) && $stable(program_status_word)
      && $stable(boot_rom_overlay_enable))
      else $error("unimplemented sfr write changed state");
   a_sfr_readzero: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ireq.rd && !i_ibit && i_sfr && !sfr_impl(sfr_addr)) |=> o_irdata == 8'h00)
      else $error("unimplemented sfr read not zero");
   a_pmc_resv: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ireq.rd && !i_ibit && i_sfr && sfr_addr == MMD_PMC_ADDR)
      |=> (o_irdata & 8'hed) == 8'h00)
      else $error("reserved control bits not zero");
   a_loader_flag: assert property (@(posedge i_clk) disable iff (i_rst)
      (pin_ok == MMD_LOADER_SEL) [*2] |-> loader_mode_flag)
      else $error("loader flag not set");
   a_bank_reset: assert property (@(posedge i_clk)
      $fell(i_rst) |-> o_bank == 2'h0)
      else $error("bank not zero after reset");

   c_rom_fetch: cover property (@(posedge i_clk) disable iff (i_rst) o_fetch_rom);
   c_unmap_rd: cover property (@(posedge i_clk) disable iff (i_rst)
      i_xreq.rd && xsel == MMD_X_NONE);
   c_bit_sfr: cover property (@(posedge i_clk) disable iff (i_rst)
      i_ireq.wr && i_ibit && sfr_hit);
   c_unimpl_wr: cover property (@(posedge i_clk) disable iff (i_rst)
      i_ireq.wr && i_sfr && !sfr_impl(sfr_addr));
   c_loader_on: cover property (@(posedge i_clk) disable iff (i_rst) $rose(loader_mode_flag));
endmodule : mmd_top
`default_nettype wire

/* sim/mmd_target_model.sv */
// Behavioural far-side target: answers external reads one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module mmd_target_model (
   input wire logic i_clk,
   input wire logic i_rd,
   input wire logic [15:0] i_addr,
   output logic [7:0] o_rdata
);
   logic [7:0] data_q = 8'h00;
   // Released bus shows a changing pattern, never the last value
   always_ff @(posedge i_clk) begin
      if (i_rd) begin
         data_q <= i_addr[7:0] ^ i_addr[15:8];
      end else begin
         data_q <= ~data_q;
      end
   end
   assign o_rdata = data_q;
endmodule : mmd_target_model
`default_nettype wire

/* sim/mmd_top_test.sv */
// Self-checking testbench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module mmd_top_test;
   import mmd_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [15:0] i_fetch_addr = 16'h0000;
   mmd_req_s i_xreq = '0;
   mmd_req_s i_ireq = '0;
   logic i_ibit = 1'b0;
   logic i_sfr = 1'b0;
   logic [2:0] i_mode_select_pins = 3'h0;
   logic [7:0] i_xrdata;
   logic o_fetch_rom, o_fetch_nvm, o_xrd, o_xwr, o_ibit_rdata, o_ibit_ok;
   logic o_loader_mode_flag, o_boot_rom_overlay_enable;
   logic [15:0] o_fetch_addr, o_xaddr;
   logic [5:0] o_xsel;
   logic [7:0] o_xwdata, o_xrdata, o_irdata;
   logic [1:0] o_bank;
   int err_count = 0;
   int comparisons = 0;
   logic [15:0] xa [13] = '{16'h0000, 16'h17ff, 16'h1800, 16'h2000, 16'h21ff, 16'h2200,
      16'h22ff, 16'h2300, 16'h24ff, 16'h2500, 16'h29ff, 16'h2a00, 16'hffff};
   logic [5:0] xs [13] = '{6'h02, 6'h02, 6'h00, 6'h04, 6'h04, 6'h08,
      6'h08, 6'h10, 6'h10, 6'h20, 6'h20, 6'h00, 6'h00};

   initial begin
      forever #2 i_clk = ~i_clk;
   end

   mmd_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_fetch_addr(i_fetch_addr),
      .o_fetch_rom(o_fetch_rom), .o_fetch_nvm(o_fetch_nvm), .o_fetch_addr(o_fetch_addr),
      .i_xreq(i_xreq), .o_xsel(o_xsel), .o_xrd(o_xrd), .o_xwr(o_xwr), .o_xaddr(o_xaddr),
      .o_xwdata(o_xwdata), .i_xrdata(i_xrdata), .o_xrdata(o_xrdata), .i_ireq(i_ireq),
      .i_ibit(i_ibit), .i_sfr(i_sfr), .o_irdata(o_irdata), .o_ibit_rdata(o_ibit_rdata),
      .o_ibit_ok(o_ibit_ok), .o_bank(o_bank), .i_mode_select_pins(i_mode_select_pins),
      .o_loader_mode_flag(o_loader_mode_flag),
      .o_boot_rom_overlay_enable(o_boot_rom_overlay_enable));

   mmd_target_model target (.i_clk(i_clk), .i_rd(o_xrd), .i_addr(o_xaddr),
      .o_rdata(i_xrdata));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk

   task automatic wrap_up;
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // Internal access; SFR space is the upper half of either address kind
   task automatic iacc(input logic rd, input logic [7:0] a, input logic [7:0] d,
                       input logic b);
      @(posedge i_clk);
      #1 i_ireq = '{rd, ~rd, {8'h00, a}, d};
      i_ibit = b;
      i_sfr = a[7];
      @(posedge i_clk);
      #1 i_ireq = '0;
   endtask : iacc

   task automatic fchk(input logic [15:0] a, input logic rom);
      @(posedge i_clk);
      #1 i_fetch_addr = a;
      #1 chk("fetch_rom", {15'h0, rom}, {15'h0, o_fetch_rom});
      chk("fetch_nvm", {15'h0, ~rom}, {15'h0, o_fetch_nvm});
      chk("fetch_addr", a, o_fetch_addr);
   endtask : fchk

   // Read then write back to back at one address
   task automatic xacc(input logic [15:0] a, input logic [5:0] s);
      @(posedge i_clk);
      #1 i_xreq = '{1'b1, 1'b0, a, 8'h00};
      #1 chk("xsel", {10'h0, s}, {10'h0, o_xsel});
      chk("xrd", {15'h0, s != 6'h00}, {15'h0, o_xrd});
      chk("xaddr", a, o_xaddr);
      @(posedge i_clk);
      #1 i_xreq = '{1'b0, 1'b1, a, 8'h3c};
      #1 chk("xwr", {15'h0, s != 6'h00}, {15'h0, o_xwr});
      chk("xwdata", 16'h003c, {8'h00, o_xwdata});
      @(posedge i_clk);
      #1 i_xreq = '0;
      chk("xrdata", (s != 6'h00) ? {8'h00, a[7:0] ^ a[15:8]} : 16'h0000,
          {8'h00, o_xrdata});
   endtask : xacc

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge i_clk);
      #1 i_rst = 1'b0;
      chk("bank", 16'h0000, {14'h0, o_bank});
      iacc(1'b1, MMD_PMC_ADDR, 8'h00, 1'b0);
      chk("pmc", 16'h0002, {8'h00, o_irdata});
      chk("overlay", 16'h0001, {15'h0, o_boot_rom_overlay_enable});
      iacc(1'b1, MMD_ACC_ADDR, 8'h00, 1'b0);
      chk("acc", 16'h0000, {8'h00, o_irdata});
      fchk(16'hfc00, 1'b0);
      fchk(16'hfbff, 1'b0);
      @(posedge i_clk);
      #1 i_mode_select_pins = 3'b100;
      repeat (8) @(posedge i_clk);
      iacc(1'b1, MMD_PMC_ADDR, 8'h00, 1'b0);
      chk("pmc", 16'h0012, {8'h00, o_irdata});
      chk("loader", 16'h0001, {15'h0, o_loader_mode_flag});
      fchk(16'hfc00, 1'b1);
      fchk(16'hffff, 1'b1);
      fchk(16'hfbff, 1'b0);
      iacc(1'b0, MMD_PMC_ADDR, 8'hff, 1'b0);
      iacc(1'b1, MMD_PMC_ADDR, 8'h00, 1'b0);
      chk("pmc", 16'h0012, {8'h00, o_irdata});
      iacc(1'b0, MMD_PMC_ADDR, 8'h00, 1'b0);
      iacc(1'b1, MMD_PMC_ADDR, 8'h00, 1'b0);
      chk("pmc", 16'h0010, {8'h00, o_irdata});
      chk("overlay", 16'h0000, {15'h0, o_boot_rom_overlay_enable});
      fchk(16'hfc00, 1'b0);
      iacc(1'b0, MMD_PMC_ADDR, 8'h02, 1'b0);
      @(posedge i_clk);
      #1 i_mode_select_pins = 3'b101;
      repeat (8) @(posedge i_clk);
      fchk(16'hfc00, 1'b0);
      chk("loader", 16'h0000, {15'h0, o_loader_mode_flag});
      chk("overlay", 16'h0001, {15'h0, o_boot_rom_overlay_enable});
      for (int k = 0; k < 13; k++) begin
         xacc(xa[k], xs[k]);
      end
      iacc(1'b0, MMD_PSW_ADDR, 8'h18, 1'b0);
      #1 chk("bank", 16'h0003, {14'h0, o_bank});
      iacc(1'b0, 8'h1f, 8'h77, 1'b0);
      iacc(1'b1, 8'h1f, 8'h00, 1'b0);
      chk("bankreg", 16'h0077, {8'h00, o_irdata});
      iacc(1'b0, 8'h30, 8'ha5, 1'b0);
      iacc(1'b1, 8'h30, 8'h00, 1'b0);
      chk("gpram", 16'h00a5, {8'h00, o_irdata});
      iacc(1'b0, 8'h21, 8'h00, 1'b0);
      iacc(1'b0, 8'h0b, 8'h01, 1'b1);
      iacc(1'b1, 8'h21, 8'h00, 1'b0);
      chk("bitbyte", 16'h0008, {8'h00, o_irdata});
      iacc(1'b1, 8'h0b, 8'h00, 1'b1);
      chk("bitrd", 16'h0001, {15'h0, o_ibit_rdata});
      chk("bitok", 16'h0001, {15'h0, o_ibit_ok});
      iacc(1'b0, MMD_ACC_ADDR, 8'h5a, 1'b0);
      iacc(1'b0, 8'he0, 8'h01, 1'b1);
      iacc(1'b1, MMD_ACC_ADDR, 8'h00, 1'b0);
      chk("accbit", 16'h005b, {8'h00, o_irdata});
      iacc(1'b0, 8'hc8, 8'hff, 1'b0);
      iacc(1'b1, 8'hc8, 8'h00, 1'b0);
      chk("unimpl", 16'h0000, {8'h00, o_irdata});
      iacc(1'b1, MMD_ACC_ADDR, 8'h00, 1'b0);
      chk("acc", 16'h005b, {8'h00, o_irdata});
      wrap_up();
   end

   // Whole run is about 120 cycles
   initial begin
      #20000;
      err_count++;
      wrap_up();
   end
endmodule : mmd_top_test
`default_nettype wire
